// File: fsam_pkg.sv
// Constants shared by the sector address map block
`default_nettype none
package fsam_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_NVCFG  = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_ADDR   = 8'h0C;
  localparam logic [7:0] OFS_ERASE  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IDDATA = 8'h18;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EXT_BIT     = 0;
  localparam int CTRL_UNIFORM_BIT = 1;
  localparam int NV_EXT_BIT       = 0;
  localparam int NV_TOP_BIT       = 1;
  localparam int ST_DONE          = 0;
  localparam int ST_WIDTH_ERR     = 1;
  localparam int ST_RANGE_ERR     = 2;
  localparam int ST_WRONG_ERASE   = 3;
  localparam int ST_ID_WR_IGN     = 4;
  localparam int ST_PARAM         = 5;
  localparam int ST_FOUR          = 6;
  localparam logic [4:0] ST_W1C_MASK = 5'h1F;
  localparam logic [1:0] NVCFG_RST   = 2'h0;
  localparam logic       UNIFORM_RST = 1'b0;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_P4E   = 8'h20;
  localparam logic [7:0] OP_4P4E  = 8'h21;
  localparam logic [7:0] OP_BE    = 8'hD8;
  localparam logic [7:0] OP_4SE   = 8'hDC;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_4READ = 8'h13;
  localparam logic [7:0] OP_FAST  = 8'h0B;
  localparam logic [7:0] OP_4FAST = 8'h0C;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_4PP   = 8'h12;
  localparam logic [7:0] OP_ID    = 8'h9F;
  // ----------------------------------------------------------------
  // Array geometry, erase lengths in 4 KB units
  // ----------------------------------------------------------------
  localparam int ARRAY_AW = 26;
  localparam logic [6:0] LEN_PARAM   = 7'd1;
  localparam logic [6:0] LEN_REMAIN  = 7'd56;
  localparam logic [6:0] LEN_UNIFORM = 7'd64;
  localparam logic [25:0] OVERLAY_SIZE = 26'h0008000;
  localparam logic [2:0] BYTES_LEGACY = 3'd3;
  localparam logic [2:0] BYTES_FULL   = 3'd4;
  localparam int ID_WORDS = 4;
  typedef enum logic [2:0] {
    FSAM_ST_RESET = 3'b001,
    FSAM_ST_LOAD  = 3'b010,
    FSAM_ST_RUN   = 3'b100
  } fsam_boot_t;
endpackage
`default_nettype wire

// File: fsam_sector_decode.sv
// Sector decoder: classifies an array address under the current layout
`timescale 1ns/1ps
`default_nettype none
module fsam_sector_decode
  import fsam_pkg::*;
(
  input  wire logic [25:0] addr,
  input  wire logic        hybrid,
  input  wire logic        top_sel,
  output logic             is_param,
  output logic             is_boundary,
  output logic [25:0]      sector_base,
  output logic [25:0]      param_base,
  output logic [25:0]      remain_base
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic [7:0] sector_idx;
  wire logic [2:0] slot;
  wire logic       edge_sector;
  wire logic       in_overlay;
  assign sector_idx  = addr[25:18];
  assign slot        = addr[17:15];
  // Boundary is the lowest or the highest uniform sector
  assign edge_sector = top_sel ? (sector_idx == 8'hFF) : (sector_idx == 8'h00); // RL10
  assign in_overlay  = top_sel ? (slot == 3'h7) : (slot == 3'h0); // RL6
  assign is_boundary = hybrid & edge_sector; // RL11
  assign is_param    = is_boundary & in_overlay;
  assign sector_base = {sector_idx, 18'h00000}; // RL12
  assign param_base  = {addr[25:12], 12'h000}; // RL13
  // Remainder skips the 32 KB overlay at either end
  assign remain_base = top_sel ? sector_base : sector_base + OVERLAY_SIZE; // RL9
endmodule
`default_nettype wire

// File: fsam_top.sv
// Flash address mode, sector map and erase targeting with an APB slave
//
// Behaviour
// RL1 - Legacy commands take 3-byte addresses by default
// RL2 - Extended mode makes legacy commands take 32 bits
// RL3 - 4-byte opcodes always take 32-bit address
// RL4 - Reset loads extended mode from nonvolatile bit
// RL5 - Secondary spaces use the same full address width
// RL6 - Eight 4 KB sectors overlay boundary 32 KB
// RL7 - Parameter sectors erase only by 20h/21h
// RL8 - Host uses D8h/DCh for all other sectors
// RL9 - Block erase of boundary spares parameter sectors
// RL10 - Top select bit places parameters top/bottom
// RL11 - Uniform select bit removes parameter sectors
// RL12 - Sector erase clears aligned 256 KB sector
// RL13 - Parameter sectors are 4 KB aligned
// RL14 - Identification opcode reads separate identification space
// RL15 - Identification space is read-only, writes ignored
// RL16 - 24-bit mode forces upper address byte zero
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fsam_top
  import fsam_pkg::*;
#(
  parameter logic [31:0] ID_WORD0 = 32'h0000A55A, // Arbitrary value
  parameter logic [31:0] ID_WORD1 = 32'h00005AA5, // Arbitrary value
  parameter logic [31:0] ID_WORD2 = 32'h00001234, // Arbitrary value
  parameter logic [31:0] ID_WORD3 = 32'h00004321  // Arbitrary value
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             erase_start,
  output logic [25:0]      erase_addr,
  output logic [6:0]       erase_len,
  output logic             array_go,
  output logic [25:0]      array_addr,
  output logic             id_sel
);
  import fsam_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic four_byte_op(input logic [7:0] op);
    four_byte_op = (op == OP_4P4E) || (op == OP_4SE) || (op == OP_4READ) ||
                   (op == OP_4FAST) || (op == OP_4PP);
  endfunction

  function automatic logic param_erase_op(input logic [7:0] op);
    param_erase_op = (op == OP_P4E) || (op == OP_4P4E);
  endfunction

  function automatic logic block_erase_op(input logic [7:0] op);
    block_erase_op = (op == OP_BE) || (op == OP_4SE);
  endfunction

  function automatic logic array_op(input logic [7:0] op);
    array_op = (op == OP_READ) || (op == OP_4READ) || (op == OP_FAST) ||
               (op == OP_4FAST) || (op == OP_PP) || (op == OP_4PP);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fsam_boot_t  boot;
  fsam_boot_t  next_boot;
  logic        ext_mode;
  logic        uniform_layout_select;
  logic [1:0]  nvcfg;
  logic [7:0]  opcode;
  logic [2:0]  addr_bytes;
  logic [31:0] addr_reg;
  logic        exec;
  logic [6:0]  status;
  logic [1:0]  id_ptr;
  logic [31:0] id_rom [0:ID_WORDS-1];

  assign id_rom[0] = ID_WORD0;
  assign id_rom[1] = ID_WORD1;
  assign id_rom[2] = ID_WORD2;
  assign id_rom[3] = ID_WORD3;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic access;
  wire logic wr_en;
  wire logic hit_ctrl;
  wire logic hit_nv;
  wire logic hit_cmd;
  wire logic hit_addr;
  wire logic hit_erase;
  wire logic hit_status;
  wire logic hit_id;
  wire logic mapped;
  assign access     = psel & penable;
  assign wr_en      = access & pwrite;
  assign hit_ctrl   = (paddr == OFS_CTRL);
  assign hit_nv     = (paddr == OFS_NVCFG);
  assign hit_cmd    = (paddr == OFS_CMD);
  assign hit_addr   = (paddr == OFS_ADDR);
  assign hit_erase  = (paddr == OFS_ERASE);
  assign hit_status = (paddr == OFS_STATUS);
  assign hit_id     = (paddr == OFS_IDDATA);
  assign mapped     = hit_ctrl | hit_nv | hit_cmd | hit_addr | hit_erase | hit_status | hit_id;
  // Zero wait states; every register but the identification data is a flop
  assign pready     = access;
  assign pslverr    = access & ~mapped;

  wire logic [31:0] rd_ctrl;
  wire logic [31:0] rd_cmd;
  wire logic [31:0] rd_erase;
  assign rd_ctrl  = {30'h0, uniform_layout_select, ext_mode};
  assign rd_cmd   = {21'h0, addr_bytes, opcode};
  assign rd_erase = {erase_len[5:0], erase_addr};
  assign prdata = hit_ctrl   ? rd_ctrl :
                  hit_nv     ? {30'h0, nvcfg} :
                  hit_cmd    ? rd_cmd :
                  hit_addr   ? addr_reg :
                  hit_erase  ? rd_erase :
                  hit_status ? {25'h0, status} :
                  hit_id     ? id_rom[id_ptr] : 32'h00000000; // RL14

  // ----------------------------------------------------------------
  // Boot sequence
  // ----------------------------------------------------------------
  always_comb begin
    case (boot)
      FSAM_ST_RESET: next_boot = FSAM_ST_LOAD;
      FSAM_ST_LOAD:  next_boot = FSAM_ST_RUN;
      FSAM_ST_RUN:   next_boot = FSAM_ST_RUN;
      default:       next_boot = FSAM_ST_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot <= FSAM_ST_RESET;
    end else begin
      boot <= next_boot;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Nonvolatile bits keep their value through every reset, like real
  // cells; software must program them once after power-up
  always_ff @(posedge pclk) begin
    if (wr_en && hit_nv) begin
      nvcfg <= pwdata[1:0];
    end
  end

  // Volatile mode is copied from the stored default after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_mode              <= 1'b0;
      uniform_layout_select <= UNIFORM_RST;
    end else if (boot == FSAM_ST_LOAD) begin
      ext_mode <= nvcfg[NV_EXT_BIT]; // RL4
    end else if (wr_en && hit_ctrl) begin
      ext_mode              <= pwdata[CTRL_EXT_BIT];
      uniform_layout_select <= pwdata[CTRL_UNIFORM_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode     <= 8'h00;
      addr_bytes <= 3'h0;
      addr_reg   <= 32'h00000000;
      exec       <= 1'b0;
    end else begin
      exec <= wr_en & hit_cmd;
      if (wr_en && hit_cmd) begin
        opcode     <= pwdata[7:0];
        addr_bytes <= pwdata[10:8];
      end
      if (wr_en && hit_addr) begin
        addr_reg <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire logic        op_four;
  wire logic [2:0]  need_bytes;
  wire logic [31:0] eff_addr;
  wire logic        width_bad;
  wire logic        range_bad;
  wire logic        is_id;
  wire logic        is_perase;
  wire logic        is_berase;
  wire logic        is_arr;
  wire logic        hybrid;
  wire logic        sd_param;
  wire logic        sd_boundary;
  wire logic [25:0] sd_sector;
  wire logic [25:0] sd_pbase;
  wire logic [25:0] sd_remain;

  assign op_four    = four_byte_op(opcode); // RL3
  // Identification space uses the same width as the array commands
  assign need_bytes = (op_four || ext_mode) ? BYTES_FULL : BYTES_LEGACY; // RL1 RL2 RL5
  assign eff_addr   = (op_four || ext_mode) ? addr_reg : {8'h00, addr_reg[23:0]}; // RL16
  assign width_bad  = (addr_bytes != need_bytes); // RL3
  assign is_id      = (opcode == OP_ID);
  assign is_perase  = param_erase_op(opcode);
  assign is_berase  = block_erase_op(opcode);
  assign is_arr     = array_op(opcode);
  assign range_bad  = ~is_id & (eff_addr[31:ARRAY_AW] != 6'h00);
  assign hybrid     = ~uniform_layout_select; // RL11

  fsam_sector_decode u_decode (
    .addr        (eff_addr[25:0]),
    .hybrid      (hybrid),
    .top_sel     (nvcfg[NV_TOP_BIT]),
    .is_param    (sd_param),
    .is_boundary (sd_boundary),
    .sector_base (sd_sector),
    .param_base  (sd_pbase),
    .remain_base (sd_remain)
  );

  wire logic cmd_ok;
  wire logic go_perase;
  wire logic go_berase;
  wire logic wrong_erase;
  assign cmd_ok      = exec & ~width_bad & ~range_bad;
  // A 4 KB erase outside the overlay starts no erase and sets the wrong-erase status flag
  assign go_perase   = cmd_ok & is_perase & sd_param; // RL7
  assign go_berase   = cmd_ok & is_berase; // RL8
  assign wrong_erase = cmd_ok & is_perase & ~sd_param;

  wire logic [25:0] next_erase_addr;
  wire logic [6:0]  next_erase_len;
  assign next_erase_addr = go_perase ? sd_pbase :
                           sd_boundary ? sd_remain : sd_sector; // RL9 RL12 RL13
  assign next_erase_len  = go_perase ? LEN_PARAM :
                           sd_boundary ? LEN_REMAIN : LEN_UNIFORM; // RL6

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_start <= 1'b0;
      erase_addr  <= 26'h0000000;
      erase_len   <= 7'h00;
      array_go    <= 1'b0;
      array_addr  <= 26'h0000000;
    end else begin
      erase_start <= go_perase | go_berase;
      array_go    <= cmd_ok & is_arr;
      if (go_perase || go_berase) begin
        erase_addr <= next_erase_addr;
        erase_len  <= next_erase_len;
      end
      if (cmd_ok && is_arr) begin
        array_addr <= eff_addr[25:0];
      end
    end
  end

  // Identification reads never touch the array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_sel <= 1'b0;
      id_ptr <= 2'h0;
    end else if (exec) begin
      id_sel <= is_id & ~width_bad; // RL14
      if (is_id && !width_bad) begin
        id_ptr <= eff_addr[3:2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, bits 4:0 write one to clear; a new event beats the clear
  // ----------------------------------------------------------------
  wire logic [4:0] st_set;
  wire logic [4:0] st_clr;
  wire logic       id_wr;
  assign id_wr  = wr_en & hit_id; // RL15
  assign st_set = {id_wr, wrong_erase, exec & range_bad, exec & width_bad, exec};
  assign st_clr = (wr_en && hit_status) ? (pwdata[4:0] & ST_W1C_MASK) : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 7'h00;
    end else begin
      status[4:0] <= st_set | (status[4:0] & ~st_clr);
      if (exec) begin
        status[ST_PARAM] <= sd_param;
        status[ST_FOUR]  <= op_four | ext_mode;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_legacy_width: assert property ( // RL1
    exec && !op_four && !ext_mode |-> need_bytes == 3'd3)
    else $error("legacy width not 3 bytes");
  chk_ext_width: assert property ( // RL2
    exec && ext_mode |-> need_bytes == 3'd4 && eff_addr == addr_reg)
    else $error("extended mode width wrong");
  chk_four_byte: assert property ( // RL3
    exec && op_four && addr_bytes != 3'd4 |=> status[ST_WIDTH_ERR] && !erase_start && !array_go)
    else $error("short 4-byte command not refused");
  chk_boot_load: assert property ( // RL4
    boot == FSAM_ST_LOAD |=> ext_mode == $past(nvcfg[NV_EXT_BIT]))
    else $error("extended mode not loaded from default");
  chk_id_width: assert property ( // RL5
    exec && is_id |-> need_bytes == (ext_mode ? 3'd4 : 3'd3))
    else $error("identification width differs");
  chk_param_erase: assert property ( // RL7
    erase_start && erase_len == 7'd1 |-> $past(param_erase_op(opcode)))
    else $error("4 KB erase from wrong opcode");
  chk_remain_only: assert property ( // RL6
    erase_start && erase_len == 7'd56 |-> $past(hybrid) && $past(block_erase_op(opcode)))
    else $error("remainder erase outside hybrid");
  chk_spare_param: assert property ( // RL9
    erase_start && erase_len == 7'd56 |-> erase_addr[17:15] == (nvcfg[NV_TOP_BIT] ? 3'h0 : 3'h1))
    else $error("block erase overlaps overlay");
  chk_top_select: assert property ( // RL10
    erase_start && erase_len == 7'd1 |-> erase_addr[25:18] == (nvcfg[NV_TOP_BIT] ? 8'hFF : 8'h00))
    else $error("parameter sector on wrong end");
  chk_uniform_only: assert property ( // RL11
    uniform_layout_select && exec |=> !erase_start || erase_len == 7'd64)
    else $error("uniform layout produced small erase");
  chk_sector_align: assert property ( // RL12
    erase_start && erase_len == 7'd64 |-> erase_addr[17:0] == 18'h00000)
    else $error("uniform erase misaligned");
  chk_param_align: assert property ( // RL13
    erase_start && erase_len == 7'd1 |-> erase_addr[11:0] == 12'h000)
    else $error("parameter erase misaligned");
  chk_id_separate: assert property ( // RL14
    exec && is_id |=> !array_go && !erase_start)
    else $error("identification read hit array");
  chk_id_readonly: assert property ( // RL15
    id_wr |=> status[ST_ID_WR_IGN] && prdata == $past(prdata) || !hit_id)
    else $error("identification write not ignored");
  chk_upper_zero: assert property ( // RL16
    exec && !op_four && !ext_mode && is_arr |=> !array_go || array_addr[25:24] == 2'h0)
    else $error("24-bit address reached past 16 MB");

  cov_param_erase: cover property (erase_start && erase_len == 7'd1);
  cov_remain_erase: cover property (erase_start && erase_len == 7'd56);
  cov_ext_read: cover property (array_go && status[ST_FOUR]);
  cov_id_read: cover property (id_sel && access && hit_id);
endmodule
`default_nettype wire

// File: fsam_host_model.sv
// Host model: issues flash commands to the block over the register bus
`timescale 1ns/1ps
`default_nettype none
module fsam_host_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // ----------------------------------------------------------------
  // One transfer
  // ----------------------------------------------------------------
  // Request held until pready is seen at an edge; bounded so a dead
  // slave cannot hang the run
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    err = 1'b0;
    q = 32'h00000000;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16 && ok == 1'b0; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        ok = 1'b1;
        q = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the sector address map block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fsam_pkg::*;
  localparam logic [31:0] ID1 = 32'h00001111; // Arbitrary value
  localparam logic [31:0] ID3 = 32'h00003333; // Arbitrary value
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  wire logic        psel, penable, pwrite, pready, pslverr;
  wire logic        erase_start, array_go, id_sel;
  wire logic [7:0]  paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic [25:0] erase_addr, array_addr;
  wire logic [6:0]  erase_len;
  int               num_errors = 0;
  int               comparisons = 0;
  logic [31:0]      rd_q;
  logic             rd_err, rd_ok;

  always #12.5 pclk = ~pclk;

  fsam_top #(.ID_WORD1(ID1), .ID_WORD3(ID3)) i_fsam_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .erase_start(erase_start),
    .erase_addr(erase_addr), .erase_len(erase_len), .array_go(array_go),
    .array_addr(array_addr), .id_sel(id_sel));

  fsam_host_model i_fsam_host_model (
    .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_fsam_host_model.xfer(wr, a, d, rd_q, rd_err, rd_ok);
    if (rd_ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t bus answer missing", $time);
      results();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk32(rd_q, exp);
  endtask

  // Reads one status flag, then clears the sticky ones
  task automatic st_chk(input int b, input logic exp);
    bus(1'b0, OFS_STATUS, 32'h00000000);
    chk32({31'h0, rd_q[b]}, {31'h0, exp});
    bus(1'b1, OFS_STATUS, {27'h0, ST_W1C_MASK});
  endtask

  // Kind: 0 refused, 1 erase, 2 array access, 3 identification read
  task automatic cmd(input logic [7:0] op, input logic [2:0] nb, input logic [31:0] a,
                     input int kind, input logic [25:0] ea, input logic [6:0] el);
    int n, ne, na;
    logic [25:0] ga;
    logic [6:0] gl;
    ne = 0;
    na = 0;
    ga = 26'h0;
    gl = 7'h0;
    bus(1'b1, OFS_ADDR, a);
    bus(1'b1, OFS_CMD, {21'h0, nb, op});
    for (n = 0; n < 6; n++) begin
      @(posedge pclk);
      if (erase_start === 1'b1) begin
        ne++;
        ga = erase_addr;
        gl = erase_len;
      end
      if (array_go === 1'b1) begin
        na++;
        ga = array_addr;
      end
    end
    if (kind == 3) begin
      chk32({31'h0, id_sel}, 32'h00000001);
    end else begin
      chk32(32'(ne), {31'h0, kind == 1});
      chk32(32'(na), {31'h0, kind == 2});
      if (kind != 0) chk32({6'h0, ga}, {6'h0, ea});
      if (kind == 1) chk32({25'h0, gl}, {25'h0, el});
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    // Nonvolatile defaults survive reset, so they are programmed while it holds
    bus(1'b1, OFS_NVCFG, 32'h00000000);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd_chk(OFS_CTRL, 32'h00000000);
    rd_chk(OFS_NVCFG, 32'h00000000);
    rd_chk(8'h1C, 32'h00000000);
    chk32({31'h0, rd_err}, 32'h00000001);
    cmd(OP_READ, 3'd3, 32'h12345678, 2, 26'h0345678, 7'd0);
    cmd(OP_READ, 3'd4, 32'h00001000, 0, 26'h0, 7'd0);
    st_chk(ST_WIDTH_ERR, 1'b1);
    cmd(OP_4READ, 3'd4, 32'h03ABCDEF, 2, 26'h3ABCDEF, 7'd0);
    cmd(OP_4PP, 3'd3, 32'h00000200, 0, 26'h0, 7'd0);
    st_chk(ST_WIDTH_ERR, 1'b1);
    cmd(OP_4READ, 3'd4, 32'h04000000, 0, 26'h0, 7'd0);
    st_chk(ST_RANGE_ERR, 1'b1);
    bus(1'b1, OFS_CTRL, 32'h00000001);
    cmd(OP_FAST, 3'd4, 32'h02000010, 2, 26'h2000010, 7'd0);
    cmd(OP_PP, 3'd3, 32'h00000010, 0, 26'h0, 7'd0);
    // Hybrid layout, parameter sectors at the bottom
    cmd(OP_P4E, 3'd4, 32'h00003123, 1, 26'h0003000, 7'd1);
    st_chk(ST_PARAM, 1'b1);
    cmd(OP_4P4E, 3'd4, 32'h00007FFF, 1, 26'h0007000, 7'd1);
    cmd(OP_BE, 3'd4, 32'h00010000, 1, 26'h0008000, 7'd56);
    rd_chk(OFS_ERASE, {6'd56, 26'h0008000});
    cmd(OP_BE, 3'd4, 32'h00000100, 1, 26'h0008000, 7'd56);
    cmd(OP_4SE, 3'd4, 32'h00123456, 1, 26'h0100000, 7'd64);
    cmd(OP_P4E, 3'd4, 32'h00008000, 0, 26'h0, 7'd0);
    st_chk(ST_WRONG_ERASE, 1'b1);
    // Parameter sectors moved to the top
    bus(1'b1, OFS_NVCFG, 32'h00000002);
    cmd(OP_4P4E, 3'd4, 32'h03FF8ABC, 1, 26'h3FF8000, 7'd1);
    cmd(OP_4P4E, 3'd4, 32'h00003000, 0, 26'h0, 7'd0);
    cmd(OP_BE, 3'd4, 32'h03FC1000, 1, 26'h3FC0000, 7'd56);
    cmd(OP_BE, 3'd4, 32'h00000000, 1, 26'h0000000, 7'd64);
    // All-uniform layout
    bus(1'b1, OFS_CTRL, 32'h00000003);
    cmd(OP_4P4E, 3'd4, 32'h03FFF000, 0, 26'h0, 7'd0);
    st_chk(ST_WRONG_ERASE, 1'b1);
    cmd(OP_4SE, 3'd4, 32'h03FFF000, 1, 26'h3FC0000, 7'd64);
    bus(1'b1, OFS_ERASE, 32'h00000000);
    rd_chk(OFS_ERASE, {6'h00, 26'h3FC0000});
    // Identification space
    cmd(OP_ID, 3'd4, 32'h00000004, 3, 26'h0, 7'd0);
    rd_chk(OFS_IDDATA, ID1);
    cmd(OP_ID, 3'd3, 32'h0000000C, 0, 26'h0, 7'd0);
    st_chk(ST_WIDTH_ERR, 1'b1);
    cmd(OP_ID, 3'd4, 32'h0000000C, 3, 26'h0, 7'd0);
    bus(1'b1, OFS_IDDATA, 32'hFFFFFFFF);
    rd_chk(OFS_IDDATA, ID3);
    st_chk(ST_ID_WR_IGN, 1'b1);
    // Second reset in mid-run
    bus(1'b1, OFS_NVCFG, 32'h00000001);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    // Extended default survives the reset and is copied into the volatile mode
    rd_chk(OFS_CTRL, 32'h00000001);
    rd_chk(OFS_NVCFG, 32'h00000001);
    cmd(OP_READ, 3'd4, 32'h02000123, 2, 26'h2000123, 7'd0);
    cmd(OP_READ, 3'd3, 32'h00000123, 0, 26'h0, 7'd0);
    st_chk(ST_WIDTH_ERR, 1'b1);
    bus(1'b1, OFS_CTRL, 32'h00000000);
    cmd(OP_READ, 3'd3, 32'hFF000123, 2, 26'h0000123, 7'd0);
    results();
  end
endmodule
`default_nettype wire
